/* File: prcg_params.svh */
// offsets, field masks, reset values and bit positions of the
// peripheral reset and clock gating registers
// assumes inclusion by bare name from the block's design files
`ifndef PRCG_PARAMS_SVH
`define PRCG_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PRCG_OFS_HS_RST   12'h00c
`define PRCG_OFS_LS_RST   12'h010
`define PRCG_OFS_SYS_GATE 12'h014
`define PRCG_OFS_HS_GATE  12'h018

// ----------------------------------------
// implemented bits and reset values
// ----------------------------------------
`define PRCG_MASK_HS      32'h0047_5a21
`define PRCG_MASK_LS      32'h107e_c932
`define PRCG_MASK_SYS     32'h005e_0055
`define PRCG_RST_HS_RST   32'h0000_0000
`define PRCG_RST_LS_RST   32'h0000_0000
`define PRCG_RST_SYS_GATE 32'h0000_0014
`define PRCG_RST_HS_GATE  32'h0000_0000

// ----------------------------------------
// bit positions
// ----------------------------------------
`define PRCG_SRAM_BIT     2
`define PRCG_FLASH_BIT    4

`endif

/* File: prcg_pkg.sv */
// types of the peripheral reset and clock gating block
// assumes nothing beyond a systemverilog compiler
package prcg_pkg;

  typedef enum logic [2:0] {
    PRCG_IDLE = 3'b001,
    PRCG_DATA = 3'b010,
    PRCG_WAIT = 3'b100
  } prcg_fsm_t;

  typedef enum logic [1:0] {
    PRCG_SEL_HS_RST   = 2'b00,
    PRCG_SEL_LS_RST   = 2'b01,
    PRCG_SEL_SYS_GATE = 2'b10,
    PRCG_SEL_HS_GATE  = 2'b11
  } prcg_sel_t;

  typedef struct packed {
    prcg_fsm_t   st;
    prcg_sel_t   sel;
    logic        hit;
    logic        wr;
    logic [3:0]  strb;
    logic        hready;
    logic [31:0] hrdata;
    logic [31:0] hs_rst;
    logic [31:0] ls_rst;
    logic [31:0] sys_gate;
    logic [31:0] hs_gate;
    logic        sram_run;
    logic        flash_run;
    logic [31:0] prd_gated;
  } prcg_state_t;

endpackage : prcg_pkg

/* File: prcg_wr_if.sv */
// write merge carrier between the register file and the merge unit
// assumes one register is written at a time
`timescale 1ns/1ps
interface prcg_wr_if;
  logic [31:0] old_val;
  logic [31:0] wdata;
  logic [31:0] mask;
  logic [3:0]  strb;
  logic [31:0] new_val;

  modport regs  (output old_val, output wdata, output mask, output strb, input new_val);
  modport merge (input old_val, input wdata, input mask, input strb, output new_val);
endinterface : prcg_wr_if

/* File: prcg_wr_merge.sv */
// byte lane merge of a register write, reserved bits forced to zero
// assumes strobes already decoded from address and size
`timescale 1ns/1ps
module prcg_wr_merge (
  prcg_wr_if.merge w
);
  // ----------------------------------------
  // per byte lane merge
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      // [RULE_13] reserved bits dropped
      assign w.new_val[8*i +: 8] = (w.strb[i] ? w.wdata[8*i +: 8] : w.old_val[8*i +: 8]) & w.mask[8*i +: 8];
    end
  endgenerate
endmodule : prcg_wr_merge

/* File: prcg_read_gate.sv */
// zeroes peripheral read data while that peripheral's clock is gated
// assumes sel[5] picks the high-speed gate register, sel[4:0] the bit
`timescale 1ns/1ps
module prcg_read_gate (
  input  wire logic [31:0] sys_gate,
  input  wire logic [31:0] hs_gate,
  input  wire logic [5:0]  sel,
  input  wire logic [31:0] rdata,
  output logic      [31:0] gated
);
  logic gate_on;

  assign gate_on = sel[5] ? hs_gate[sel[4:0]] : sys_gate[sel[4:0]];
  // [RULE_09] gated clock reads zero
  assign gated   = gate_on ? rdata : 32'h0000_0000;
endmodule : prcg_read_gate

/* File: prcg_top.sv */
// peripheral reset and clock gating registers behind an ahb-lite slave
// assumes single-slave bus, hready fed back from hreadyout,
// hs_bus_busy high while a high-speed bus peripheral access runs
//
// Behaviour
// [RULE_01] a reset field at 1 holds its peripheral in reset, at 0 it has no effect.
// [RULE_02] the high-speed reset register is at 0x0C, resets to zero, bits 0,5,9,11,12,14,16-18,22.
// [RULE_03] the low-speed reset register is at 0x10, resets to zero, bits 1,4,5,8,11,14,15,17-22,28.
// [RULE_04] the system-bus gate register is at 0x14 and resets to 0x14, sram and flash on.
// [RULE_05] the sram enable bit decides if the sram clock runs in sleep.
// [RULE_06] the flash enable bit decides if the flash interface clock runs in sleep.
// [RULE_07] system-bus gate bits 0 dma, 6 crc, 17-20 ports a-d, 22 port f.
// [RULE_08] the high-speed gate register is at 0x18, resets to zero, same bits as its reset twin.
// [RULE_09] a peripheral whose clock is gated reads back zero.
// [RULE_10] the high-speed gate register waits while a high-speed bus access is in progress.
// [RULE_11] all registers take byte, half and word access; the other three never wait.
// [RULE_12] every implemented bit can be set and cleared by software.
// [RULE_13] reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "prcg_params.svh"
module prcg_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        sleep_mode,
  input  wire logic        hs_bus_busy,
  input  wire logic [5:0]  periph_rd_sel,
  input  wire logic [31:0] periph_rdata,
  output logic      [31:0] periph_rdata_gated,
  output logic      [31:0] hs_periph_reset,
  output logic      [31:0] ls_periph_reset,
  output logic      [31:0] sys_clk_gate,
  output logic      [31:0] hs_clk_gate,
  output logic             sram_clk_run,
  output logic             flash_clk_run
);
  import prcg_pkg::*;

  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  prcg_state_t s_r;
  prcg_state_t s_nxt;
  logic        cap;
  logic        cap_hit;
  prcg_sel_t   cap_sel;
  logic [3:0]  cap_strb;
  logic        wr_fire;
  logic [31:0] prd_gated;
  logic [11:0] word_ofs;
  logic [31:0] strb_bits;

  prcg_wr_if wif ();

  prcg_wr_merge u_merge (
    .w (wif.merge)
  );

  prcg_read_gate u_rgate (
    .sys_gate (s_r.sys_gate),
    .hs_gate  (s_r.hs_gate),
    .sel      (periph_rd_sel),
    .rdata    (periph_rdata),
    .gated    (prd_gated)
  );

  // ----------------------------------------
  // address phase decode
  // ----------------------------------------
  assign cap = hsel && htrans[1] && hready;
  // [RULE_11] sub-word offsets alias
  assign word_ofs = {haddr[11:2], 2'b00};

  always_comb begin
    cap_hit = 1'b1;
    cap_sel = PRCG_SEL_HS_RST;
    if (word_ofs == `PRCG_OFS_HS_RST) begin
      cap_sel = PRCG_SEL_HS_RST;
    end else if (word_ofs == `PRCG_OFS_LS_RST) begin
      cap_sel = PRCG_SEL_LS_RST;
    end else if (word_ofs == `PRCG_OFS_SYS_GATE) begin
      cap_sel = PRCG_SEL_SYS_GATE;
    end else if (word_ofs == `PRCG_OFS_HS_GATE) begin
      cap_sel = PRCG_SEL_HS_GATE;
    end else begin
      cap_hit = 1'b0;
    end
  end

  // [RULE_11] byte, half and word lanes
  always_comb begin
    case (hsize)
      3'b000:  cap_strb = 4'b0001 << haddr[1:0];
      3'b001:  cap_strb = haddr[1] ? 4'b1100 : 4'b0011;
      default: cap_strb = 4'b1111;
    endcase
  end

  // ----------------------------------------
  // write merge feed
  // ----------------------------------------
  assign wif.wdata = hwdata;
  assign wif.strb  = s_r.strb;
  assign strb_bits = {{8{s_r.strb[3]}}, {8{s_r.strb[2]}}, {8{s_r.strb[1]}}, {8{s_r.strb[0]}}};

  always_comb begin
    case (s_r.sel)
      PRCG_SEL_HS_RST: begin
        wif.old_val = s_r.hs_rst;
        wif.mask    = `PRCG_MASK_HS;
      end
      PRCG_SEL_LS_RST: begin
        wif.old_val = s_r.ls_rst;
        wif.mask    = `PRCG_MASK_LS;
      end
      PRCG_SEL_SYS_GATE: begin
        wif.old_val = s_r.sys_gate;
        wif.mask    = `PRCG_MASK_SYS;
      end
      default: begin
        wif.old_val = s_r.hs_gate;
        wif.mask    = `PRCG_MASK_HS;
      end
    endcase
  end

  function automatic logic [31:0] rd_val(input prcg_state_t s, input prcg_sel_t sel);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (sel)
      PRCG_SEL_HS_RST:   v = s.hs_rst;
      PRCG_SEL_LS_RST:   v = s.ls_rst;
      PRCG_SEL_SYS_GATE: v = s.sys_gate;
      default:           v = s.hs_gate;
    endcase
    return v;
  endfunction : rd_val

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt   = s_r;
    wr_fire = 1'b0;
    case (s_r.st)
      PRCG_DATA: begin
        s_nxt.st = PRCG_IDLE;
        if (s_r.wr && s_r.hit) begin
          wr_fire = 1'b1;
          // [RULE_12] software sets and clears
          case (s_r.sel)
            PRCG_SEL_HS_RST:   s_nxt.hs_rst   = wif.new_val;
            PRCG_SEL_LS_RST:   s_nxt.ls_rst   = wif.new_val;
            PRCG_SEL_SYS_GATE: s_nxt.sys_gate = wif.new_val;
            default:           s_nxt.hs_gate  = wif.new_val;
          endcase
        end
      end
      PRCG_WAIT: begin
        // [RULE_10] release once bus idle
        if (!hs_bus_busy) begin
          s_nxt.st     = PRCG_DATA;
          s_nxt.hready = 1'b1;
          s_nxt.hrdata = s_r.wr ? 32'h0000_0000 : rd_val(s_r, s_r.sel);
        end
      end
      default: begin
        s_nxt.st = PRCG_IDLE;
      end
    endcase
    if (cap) begin
      s_nxt.sel    = cap_sel;
      s_nxt.hit    = cap_hit;
      s_nxt.wr     = hwrite;
      s_nxt.strb   = cap_strb;
      s_nxt.hrdata = 32'h0000_0000;
      // [RULE_10] stall high-speed gate access
      if (cap_hit && cap_sel == PRCG_SEL_HS_GATE && hs_bus_busy) begin
        s_nxt.st     = PRCG_WAIT;
        s_nxt.hready = 1'b0;
      end else begin
        // [RULE_11] zero wait answer
        s_nxt.st     = PRCG_DATA;
        s_nxt.hready = 1'b1;
        if (cap_hit && !hwrite) begin
          s_nxt.hrdata = rd_val(s_nxt, cap_sel);
        end
      end
    end else if (s_nxt.st == PRCG_IDLE) begin
      s_nxt.hready = 1'b1;
      s_nxt.hrdata = 32'h0000_0000;
    end
    // [RULE_05] sram clock in sleep
    s_nxt.sram_run  = s_nxt.sys_gate[`PRCG_SRAM_BIT] | ~sleep_mode;
    // [RULE_06] flash clock in sleep
    s_nxt.flash_run = s_nxt.sys_gate[`PRCG_FLASH_BIT] | ~sleep_mode;
    s_nxt.prd_gated = prd_gated;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r.st        <= PRCG_IDLE;
      s_r.sel       <= PRCG_SEL_HS_RST;
      s_r.hit       <= 1'b0;
      s_r.wr        <= 1'b0;
      s_r.strb      <= 4'h0;
      s_r.hready    <= 1'b1;
      s_r.hrdata    <= 32'h0000_0000;
      // [RULE_02] cleared at reset
      s_r.hs_rst    <= `PRCG_RST_HS_RST;
      // [RULE_03] cleared at reset
      s_r.ls_rst    <= `PRCG_RST_LS_RST;
      // [RULE_04] sram and flash on
      s_r.sys_gate  <= `PRCG_RST_SYS_GATE;
      // [RULE_08] cleared at reset
      s_r.hs_gate   <= `PRCG_RST_HS_GATE;
      s_r.sram_run  <= 1'b1;
      s_r.flash_run <= 1'b1;
      s_r.prd_gated <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout          = s_r.hready;
  assign hrdata             = s_r.hrdata;
  assign hresp              = 1'b0;
  assign periph_rdata_gated = s_r.prd_gated;
  // [RULE_01] reset held while field is one
  assign hs_periph_reset    = s_r.hs_rst;
  assign ls_periph_reset    = s_r.ls_rst;
  // [RULE_07] system-bus clock gates
  assign sys_clk_gate       = s_r.sys_gate;
  assign hs_clk_gate        = s_r.hs_gate;
  assign sram_clk_run       = s_r.sram_run;
  assign flash_clk_run      = s_r.flash_run;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence hs_gate_busy_s;
    cap && cap_hit && cap_sel == PRCG_SEL_HS_GATE && hs_bus_busy;
  endsequence

  sequence wait_release_s;
    s_r.st == PRCG_WAIT && !hs_bus_busy;
  endsequence

  rst_hold_a: assert property (!wr_fire |=> $stable(s_r.ls_rst) && $stable(s_r.hs_rst)) // [RULE_01]
    else $error("reset field changed without a write");

  hs_rst_write_a: assert property ( // [RULE_02]
    wr_fire && s_r.sel == PRCG_SEL_HS_RST
    |=> hs_periph_reset == ($past((s_r.hs_rst & ~strb_bits) | (hwdata & strb_bits)) & `PRCG_MASK_HS))
    else $error("high-speed reset write lost");

  ls_rst_write_a: assert property ( // [RULE_03]
    wr_fire && s_r.sel == PRCG_SEL_LS_RST
    |=> ls_periph_reset == ($past((s_r.ls_rst & ~strb_bits) | (hwdata & strb_bits)) & `PRCG_MASK_LS))
    else $error("low-speed reset write lost");

  sys_reset_val_a: assert property ( // [RULE_04]
    $rose(hresetn) |-> sys_clk_gate == `PRCG_RST_SYS_GATE && hs_clk_gate == `PRCG_RST_HS_GATE
    && hs_periph_reset == `PRCG_RST_HS_RST && ls_periph_reset == `PRCG_RST_LS_RST)
    else $error("register reset value wrong");

  sram_sleep_a: assert property (sleep_mode && !wr_fire && !s_r.sys_gate[`PRCG_SRAM_BIT] |=> !sram_clk_run) // [RULE_05]
    else $error("sram clock runs in sleep while disabled");

  flash_wake_a: assert property (!sleep_mode |=> flash_clk_run) // [RULE_06]
    else $error("flash clock stopped while awake");

  sys_word_set_a: assert property ( // [RULE_07]
    wr_fire && s_r.sel == PRCG_SEL_SYS_GATE && s_r.strb == 4'hf
    |=> sys_clk_gate == ($past(hwdata) & `PRCG_MASK_SYS))
    else $error("system gate word write wrong");

  hs_gate_write_a: assert property ( // [RULE_08]
    wr_fire && s_r.sel == PRCG_SEL_HS_GATE
    |=> hs_clk_gate == ($past((s_r.hs_gate & ~strb_bits) | (hwdata & strb_bits)) & `PRCG_MASK_HS))
    else $error("high-speed gate write lost");

  rd_gate_a: assert property ( // [RULE_09]
    periph_rd_sel[5] && !hs_clk_gate[periph_rd_sel[4:0]] |=> periph_rdata_gated == 32'h0000_0000)
    else $error("gated peripheral read not zero");

  hs_stall_a: assert property (hs_gate_busy_s |=> !hreadyout && s_r.st == PRCG_WAIT) // [RULE_10]
    else $error("no wait state on busy high-speed bus");

  hs_release_a: assert property (wait_release_s |=> hreadyout && s_r.st == PRCG_DATA) // [RULE_10]
    else $error("wait state not released");

  no_wait_a: assert property (cap && !(cap_sel == PRCG_SEL_HS_GATE && cap_hit) |=> hreadyout) // [RULE_11]
    else $error("unexpected wait state");

  byte_write_a: assert property ( // [RULE_12]
    wr_fire && s_r.strb == 4'b0001
    |=> (rd_val(s_r, $past(s_r.sel)) & 32'hffff_ff00) == ($past(wif.old_val) & 32'hffff_ff00))
    else $error("byte write touched other lanes");

  resv_zero_a: assert property ( // [RULE_13]
    ((hs_periph_reset | hs_clk_gate) & ~`PRCG_MASK_HS) == 32'h0000_0000
    && (ls_periph_reset & ~`PRCG_MASK_LS) == 32'h0000_0000
    && (sys_clk_gate & ~`PRCG_MASK_SYS) == 32'h0000_0000)
    else $error("reserved bit set");

  sram_wake_a: assert property ( // [RULE_05]
    !sleep_mode |=> sram_clk_run)
    else $error("sram clock stopped while awake");

  flash_sleep_a: assert property ( // [RULE_06]
    sleep_mode && !wr_fire && !s_r.sys_gate[`PRCG_FLASH_BIT] |=> !flash_clk_run)
    else $error("flash clock runs in sleep while disabled");

  sys_rd_gate_a: assert property ( // [RULE_09]
    !periph_rd_sel[5] && !sys_clk_gate[periph_rd_sel[4:0]] |=> periph_rdata_gated == 32'h0000_0000)
    else $error("system gated peripheral read not zero");

  rd_pass_a: assert property ( // [RULE_09]
    (periph_rd_sel[5] ? hs_clk_gate[periph_rd_sel[4:0]] : sys_clk_gate[periph_rd_sel[4:0]])
    |=> periph_rdata_gated == $past(periph_rdata))
    else $error("enabled peripheral read not passed");

  wait_hold_a: assert property ( // [RULE_10]
    s_r.st == PRCG_WAIT && hs_bus_busy |=> !hreadyout && s_r.st == PRCG_WAIT)
    else $error("wait state ended while bus busy");

  idle_data_a: assert property ( // [RULE_11]
    s_r.st == PRCG_IDLE |-> hreadyout && hrdata == 32'h0000_0000)
    else $error("idle bus not ready or data not zero");

  rd_answer_a: assert property ( // [RULE_12]
    s_r.st == PRCG_DATA && !s_r.wr && s_r.hit
    |-> hrdata == (s_r.sel == PRCG_SEL_HS_RST ? hs_periph_reset : s_r.sel == PRCG_SEL_LS_RST ? ls_periph_reset
                   : s_r.sel == PRCG_SEL_SYS_GATE ? sys_clk_gate : hs_clk_gate))
    else $error("read answer differs from register");

  unmapped_rd_a: assert property ( // [RULE_13]
    s_r.st == PRCG_DATA && !s_r.hit |-> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule : prcg_top

/* File: prcg_tb_top.sv */
// self-checking bench of the peripheral reset and clock gating block
// assumes prcg_top as the only slave, its hreadyout fed back as hready
`timescale 1ns/1ps
module prcg_tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        sleep_mode;
  logic        hs_bus_busy;
  logic [5:0]  periph_rd_sel;
  logic [31:0] periph_rdata;
  logic [31:0] periph_rdata_gated;
  logic [31:0] hs_periph_reset;
  logic [31:0] ls_periph_reset;
  logic [31:0] sys_clk_gate;
  logic [31:0] hs_clk_gate;
  logic        sram_clk_run;
  logic        flash_clk_run;
  logic [31:0] d;
  int          w;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  localparam logic [11:0] reg_ofs [4] = '{12'h00c, 12'h010, 12'h014, 12'h018};
  localparam logic [31:0] reg_msk [4] = '{32'h0047_5a21, 32'h107e_c932, 32'h005e_0055, 32'h0047_5a21};
  localparam logic [31:0] reg_rst [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0014, 32'h0000_0000};

  prcg_top uut (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .hsel               (hsel),
    .haddr              (haddr),
    .htrans             (htrans),
    .hwrite             (hwrite),
    .hsize              (hsize),
    .hwdata             (hwdata),
    .hready             (hreadyout),
    .hreadyout          (hreadyout),
    .hrdata             (hrdata),
    .hresp              (hresp),
    .sleep_mode         (sleep_mode),
    .hs_bus_busy        (hs_bus_busy),
    .periph_rd_sel      (periph_rd_sel),
    .periph_rdata       (periph_rdata),
    .periph_rdata_gated (periph_rdata_gated),
    .hs_periph_reset    (hs_periph_reset),
    .ls_periph_reset    (ls_periph_reset),
    .sys_clk_gate       (sys_clk_gate),
    .hs_clk_gate        (hs_clk_gate),
    .sram_clk_run       (sram_clk_run),
    .flash_clk_run      (flash_clk_run)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("ERROR at %0t: bench timeout", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // ahb-lite single transfer
  // ----------------------------------------
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [2:0] sz, input logic [31:0] wd,
                     output logic [31:0] rd, output int waits);
    waits = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0_0000, a};
    hwrite <= wr;
    hsize  <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      waits++;
      @(posedge hclk);
    end
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [11:0] a, input logic [2:0] sz, input logic [31:0] wd);
    logic [31:0] r;
    int          n;
    ahb(1'b1, a, sz, wd, r, n);
  endtask : wr

  function automatic logic [31:0] port_of(input int i);
    case (i)
      0: return hs_periph_reset;
      1: return ls_periph_reset;
      2: return sys_clk_gate;
      default: return hs_clk_gate;
    endcase
  endfunction : port_of

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = '0;
    sleep_mode = 1'b0;
    hs_bus_busy = 1'b0;
    periph_rd_sel = '0;
    periph_rdata = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, reg_ofs[i], 3'h2, '0, d, w);
      check(d, reg_rst[i], "reset read");
      check(port_of(i), reg_rst[i], "reset port");
    end
    check({30'h0, sram_clk_run, flash_clk_run}, 32'h0000_0003, "run at reset");
    $display("test reset_values done");
    for (int i = 0; i < 4; i++) begin
      wr(reg_ofs[i], 3'h2, 32'hffff_ffff);
      ahb(1'b0, reg_ofs[i], 3'h2, '0, d, w);
      check(d, reg_msk[i], "set read");
      check(port_of(i), reg_msk[i], "set port");
      check(32'(w), 32'h0000_0000, "no wait");
      wr(reg_ofs[i], 3'h2, 32'h0000_0000);
      ahb(1'b0, reg_ofs[i], 3'h2, '0, d, w);
      check(d, 32'h0000_0000, "clear read");
      check(port_of(i), 32'h0000_0000, "clear port");
    end
    $display("test set_clear done");
    wr(12'h012, 3'h0, 32'hffff_ffff);
    ahb(1'b0, 12'h010, 3'h2, '0, d, w);
    check(d, 32'h007e_0000, "byte lane");
    wr(12'h010, 3'h1, 32'hffff_ffff);
    ahb(1'b0, 12'h010, 3'h2, '0, d, w);
    check(d, 32'h007e_c932, "half lane");
    wr(12'h016, 3'h0, 32'hffff_ffff);
    wr(12'h017, 3'h0, 32'hffff_ffff);
    ahb(1'b0, 12'h014, 3'h2, '0, d, w);
    check(d, 32'h005e_0000, "top byte reserved");
    wr(12'h00c, 3'h3, 32'hffff_ffff);
    ahb(1'b0, 12'h00c, 3'h2, '0, d, w);
    check(d, 32'h0047_5a21, "wide size as word");
    $display("test lanes done");
    wr(12'h01c, 3'h2, 32'hffff_ffff);
    ahb(1'b0, 12'h01c, 3'h2, '0, d, w);
    check(d, 32'h0000_0000, "unmapped read");
    check({hresp, 31'h0}, 32'h0000_0000, "okay response");
    $display("test unmapped done");
    @(posedge hclk);
    hs_bus_busy <= 1'b1;
    fork
      ahb(1'b1, 12'h018, 3'h2, 32'h0040_0001, d, w);
      begin
        repeat (4) @(posedge hclk);
        hs_bus_busy <= 1'b0;
      end
    join
    check(32'(w), 32'h0000_0003, "busy waits");
    ahb(1'b0, 12'h018, 3'h2, '0, d, w);
    check(d, 32'h0040_0001, "write under busy");
    check(32'(w), 32'h0000_0000, "idle no wait");
    @(posedge hclk);
    hs_bus_busy <= 1'b1;
    fork
      ahb(1'b0, 12'h018, 3'h2, '0, d, w);
      begin
        repeat (2) @(posedge hclk);
        hs_bus_busy <= 1'b0;
      end
    join
    check(d, 32'h0040_0001, "read under busy");
    check(32'(w), 32'h0000_0001, "busy read waits");
    @(posedge hclk);
    hs_bus_busy <= 1'b1;
    ahb(1'b0, 12'h014, 3'h2, '0, d, w);
    check(32'(w), 32'h0000_0000, "system gate no wait");
    @(posedge hclk);
    hs_bus_busy <= 1'b0;
    $display("test wait_states done");
    wr(12'h014, 3'h2, 32'h0000_0010);
    @(posedge hclk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge hclk);
    check({30'h0, sram_clk_run, flash_clk_run}, 32'h0000_0001, "sleep flash only");
    wr(12'h014, 3'h2, 32'h0000_0004);
    repeat (2) @(posedge hclk);
    check({30'h0, sram_clk_run, flash_clk_run}, 32'h0000_0002, "sleep sram only");
    sleep_mode <= 1'b0;
    repeat (2) @(posedge hclk);
    check({30'h0, sram_clk_run, flash_clk_run}, 32'h0000_0003, "awake both");
    $display("test sleep done");
    periph_rd_sel <= {1'b1, 5'd5};
    periph_rdata  <= 32'ha5a5_5a5a;
    repeat (2) @(posedge hclk);
    check(periph_rdata_gated, 32'h0000_0000, "gated read");
    wr(12'h018, 3'h2, 32'h0000_0020);
    repeat (2) @(posedge hclk);
    check(periph_rdata_gated, 32'ha5a5_5a5a, "enabled read");
    periph_rd_sel <= {1'b0, 5'd2};
    repeat (2) @(posedge hclk);
    check(periph_rdata_gated, 32'ha5a5_5a5a, "system enabled read");
    periph_rd_sel <= {1'b0, 5'd4};
    repeat (2) @(posedge hclk);
    check(periph_rdata_gated, 32'h0000_0000, "system gated read");
    $display("test read_gate done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, reg_ofs[i], 3'h2, '0, d, w);
      check(d, reg_rst[i], "rerun reset read");
    end
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule : prcg_tb_top
